// File: src/clock_controller_pkg.sv
// Overview of operation
// - reset runs fast RC divided by eight
// - software changes source at run time
// - old source kept until new ready
// - core and each peripheral clock stoppable
// - wakeup on fast RC/8, then restore
// - external failure forces fast RC at 2 MHz
// - external failure raises an interrupt
// - selectable clock driven on output pin
// - trim register: three magnitude, one sign
// - option bit: two magnitude bits plus sign
// - slow RC feeds watchdog and wakeup timer
// - slow RC system clock needs option bit
// - crystal selectable as main run clock
// - user external clock accepted on input
// - gate bits map to peripherals as listed
package clock_controller_pkg;

   typedef enum logic [1:0]
   {
      SRC_FAST_RC  = 2'h0,
      SRC_SLOW_RC  = 2'h1,
      SRC_CRYSTAL  = 2'h2,
      SRC_USER_EXT = 2'h3
   } source_type;

   // gray along run -> switch and run -> halt -> stabilize
   typedef enum logic [1:0]
   {
      ST_RUN       = 2'h0,
      ST_SWITCH    = 2'h1,
      ST_HALT      = 2'h2,
      ST_STABILIZE = 2'h3
   } state_type;

   // register byte addresses
   localparam logic [7:0] ADDR_SOURCE_SELECT = 8'h00;
   localparam logic [7:0] ADDR_SOURCE_STATUS = 8'h04;
   localparam logic [7:0] ADDR_DIVIDER       = 8'h08;
   localparam logic [7:0] ADDR_TRIM          = 8'h0C;
   localparam logic [7:0] ADDR_GATE_1        = 8'h10;
   localparam logic [7:0] ADDR_GATE_2        = 8'h14;
   localparam logic [7:0] ADDR_CLOCK_OUT     = 8'h18;
   localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_MASK      = 8'h20;
   localparam logic [7:0] ADDR_CONTROL       = 8'h24;

   // field positions
   localparam int CTRL_CORE_STOP   = 0;
   localparam int CTRL_MONITOR_EN  = 1;
   localparam int IRQ_FAIL         = 0;
   localparam int IRQ_SWITCH_DONE  = 1;
   localparam int CLKOUT_ENABLE    = 0;
   localparam int GATE2_AWU        = 2;

   // reset values
   localparam logic [1:0] DIV_BY_EIGHT    = 2'h3;
   localparam logic [7:0] GATE_1_RESET    = 8'hFB;
   localparam logic [7:0] GATE_2_RESET    = 8'h0C;
   localparam logic [1:0] CONTROL_RESET   = 2'h2;
   localparam logic [3:0] TRIM_RESET      = 4'h0;

   // writable bits; reserved gate bits read zero
   localparam logic [7:0] GATE_1_VALID    = 8'hFB;
   localparam logic [7:0] GATE_2_VALID    = 8'h0C;
   // compatibility trim keeps sign and two low magnitude bits
   localparam logic [3:0] TRIM_COMPAT_MASK = 4'hB;

   // timing at a 100 ns clock
   localparam int CLOCK_PERIOD_NS = 100;
   localparam int STAB_TIME_NS    = 10000;
   localparam int FAIL_TIME_NS    = 8000;
   localparam int STAB_CYCLES_INT = (STAB_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int FAIL_CYCLES_INT = FAIL_TIME_NS / CLOCK_PERIOD_NS;
   localparam logic [7:0] STAB_CYCLES = 8'(STAB_CYCLES_INT);
   localparam logic [7:0] FAIL_CYCLES = 8'(FAIL_CYCLES_INT);

endpackage : clock_controller_pkg

// File: src/clock_tick_divider.sv
`timescale 1ns/1ps
module clock_tick_divider
   import clock_controller_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // source ticks
   input  wire logic       tickIn,
   input  wire logic [1:0] divSelect,
   input  wire logic       restart,
   // divided ticks
   output logic            tickOut
);

   logic [2:0] count;
   logic [2:0] limit;

   // divide by 1, 2, 4 or 8 source ticks
   always_comb
   begin
      limit = 3'((4'h1 << divSelect) - 4'h1);
   end

   // restart on a source change so the first divided tick is a full period
   always_ff @(posedge clock)
   begin
      if (!rst_n || restart)
      begin
         count   <= 3'h0;
         tickOut <= 1'b0;
      end
      else if (tickIn)
      begin
         tickOut <= (count >= limit);
         count   <= (count >= limit) ? 3'h0 : 3'(count + 3'h1);
      end
      else
      begin
         tickOut <= 1'b0;
      end
   end

endmodule : clock_tick_divider

// File: src/system_clock_controller.sv
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
module system_clock_controller
   import clock_controller_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // wishbone slave
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   input  wire logic        wbWe,
   input  wire logic [7:0]  wbAdr,
   input  wire logic [3:0]  wbSel,
   input  wire logic [31:0] wbDatIn,
   output logic [31:0]      wbDatOut,
   output logic             wbAck,
   // oscillators, sampled as pins
   input  wire logic        fastRcTick,
   input  wire logic        slowRcTick,
   input  wire logic        extClockTick,
   input  wire logic        fastRcReady,
   input  wire logic        slowRcReady,
   input  wire logic        crystalReady,
   // option byte straps
   input  wire logic        trimCompatSelect,
   input  wire logic        slowRcSysclkAllow,
   // power mode requests from the core
   input  wire logic        haltRequest,
   input  wire logic        wakeupEvent,
   // clock ticks
   output logic             sysTick,
   output logic             coreTick,
   output logic [15:0]      periphTick,
   output logic             watchdogTick,
   output logic             awuTick,
   // oscillator trim and clock output pin
   output logic [3:0]       trimValue,
   output logic             clockOutPin,
   output logic             clockOutEnable,
   // status
   output logic             irq,
   output logic             halted,
   output logic [1:0]       activeSource
);
   import clock_controller_pkg::*;

   localparam int SYNC_W = 8;

   logic [SYNC_W-1:0] syncA;
   logic [SYNC_W-1:0] syncB;
   logic [SYNC_W-1:0] pinIn;
   logic [2:0]        tickPrev;
   logic              fastEdge;
   logic              slowEdge;
   logic              extEdge;
   logic              trimCompat;
   logic              slowAllow;

   source_type        selectReg;
   source_type        currentSource;
   state_type         state;
   logic [1:0]        divReg;
   logic [3:0]        trimReg;
   logic [7:0]        gate1;
   logic [7:0]        gate2;
   logic [2:0]        clockOutReg;
   logic [1:0]        irqStatus;
   logic [1:0]        irqMask;
   logic [1:0]        control;
   logic [7:0]        stabCount;
   logic [7:0]        silentCount;
   logic              extAlive;
   logic              failEvent;
   logic              switchDone;
   logic              sourceTick;
   logic              divTick;
   logic [1:0]        effDiv;
   logic              restartDiv;
   logic              running;
   logic              busReq;
   logic              busWrite;
   logic [31:0]       readData;
   logic [15:0]       gateAll;
   logic              outSelTick;

   assign pinIn = {slowRcSysclkAllow, trimCompatSelect, crystalReady, slowRcReady, fastRcReady,
                   extClockTick, slowRcTick, fastRcTick};

   // two stages on every pin; only the second stage is read
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++)
      begin : g_sync
         always_ff @(posedge clock)
         begin
            if (!rst_n)
            begin
               syncA[gi] <= 1'b0;
               syncB[gi] <= 1'b0;
            end
            else
            begin
               syncA[gi] <= pinIn[gi];
               syncB[gi] <= syncA[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         tickPrev <= 3'h0;
      else
         tickPrev <= syncB[2:0];
   end

   assign fastEdge   = syncB[0] & ~tickPrev[0];
   assign slowEdge   = syncB[1] & ~tickPrev[1];
   assign extEdge    = syncB[2] & ~tickPrev[2];
   assign trimCompat = syncB[6];
   assign slowAllow  = syncB[7];

   function automatic logic sourceReady(input source_type src);
      case (src)
         SRC_FAST_RC:  sourceReady = syncB[3];
         SRC_SLOW_RC:  sourceReady = syncB[4];
         SRC_CRYSTAL:  sourceReady = syncB[5];
         SRC_USER_EXT: sourceReady = extAlive;
         default:      sourceReady = 1'b0;
      endcase
   endfunction : sourceReady

   // wishbone: ack one cycle after the request, write lands on the ack edge
   assign busReq   = wbCyc & wbStb;
   assign busWrite = busReq & wbAck & wbWe & wbSel[0];

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         wbAck    <= 1'b0;
         wbDatOut <= 32'h0;
      end
      else
      begin
         wbAck    <= busReq & ~wbAck;
         wbDatOut <= (busReq & ~wbAck) ? readData : 32'h0;
      end
   end

   always_comb
   begin
      readData = 32'h0;
      case (wbAdr)
         ADDR_SOURCE_SELECT: readData[1:0] = selectReg;
         ADDR_SOURCE_STATUS: readData[7:0] = {syncB[5:3], extAlive, state, currentSource};
         ADDR_DIVIDER:       readData[1:0] = divReg;
         ADDR_TRIM:          readData[3:0] = trimReg;
         ADDR_GATE_1:        readData[7:0] = gate1 & GATE_1_VALID;
         ADDR_GATE_2:        readData[7:0] = gate2 & GATE_2_VALID;
         ADDR_CLOCK_OUT:     readData[2:0] = clockOutReg;
         ADDR_IRQ_STATUS:    readData[1:0] = irqStatus;
         ADDR_IRQ_MASK:      readData[1:0] = irqMask;
         ADDR_CONTROL:       readData[1:0] = control;
         default:            readData = 32'h0;
      endcase
   end

   // source selection; a refused slow RC request leaves the target unchanged
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         selectReg <= SRC_FAST_RC;
      else if (failEvent)
         selectReg <= SRC_FAST_RC;
      else if (busWrite && wbAdr == ADDR_SOURCE_SELECT)
      begin
         if (source_type'(wbDatIn[1:0]) != SRC_SLOW_RC || slowAllow)
            selectReg <= source_type'(wbDatIn[1:0]);
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         divReg <= DIV_BY_EIGHT;
      else if (failEvent)
         divReg <= DIV_BY_EIGHT;
      else if (busWrite && wbAdr == ADDR_DIVIDER)
         divReg <= wbDatIn[1:0];
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         trimReg     <= TRIM_RESET;
         gate1       <= GATE_1_RESET;
         gate2       <= GATE_2_RESET;
         clockOutReg <= 3'h0;
         irqMask     <= 2'h0;
         control     <= CONTROL_RESET;
      end
      else if (busWrite)
      begin
         case (wbAdr)
            ADDR_TRIM:      trimReg     <= wbDatIn[3:0];
            ADDR_GATE_1:    gate1       <= wbDatIn[7:0] & GATE_1_VALID;
            ADDR_GATE_2:    gate2       <= wbDatIn[7:0] & GATE_2_VALID;
            ADDR_CLOCK_OUT: clockOutReg <= wbDatIn[2:0];
            ADDR_IRQ_MASK:  irqMask     <= wbDatIn[1:0];
            ADDR_CONTROL:   control     <= wbDatIn[1:0];
            default:        control     <= control;
         endcase
      end
   end

   // sticky events; a new event outweighs a write-one clear in the same cycle
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         irqStatus <= 2'h0;
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if ((i == IRQ_FAIL && failEvent) || (i == IRQ_SWITCH_DONE && switchDone))
               irqStatus[i] <= 1'b1;
            else if (busWrite && wbAdr == ADDR_IRQ_STATUS && wbDatIn[i])
               irqStatus[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= |(irqStatus & irqMask);
   end

   // failure monitor counts cycles without an external edge; saturates when silent
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         silentCount <= FAIL_CYCLES;
      else if (extEdge)
         silentCount <= 8'h0;
      else if (silentCount < FAIL_CYCLES)
         silentCount <= 8'(silentCount + 8'h1);
   end

   assign extAlive  = silentCount < FAIL_CYCLES;
   // fires once, on the cycle the count runs out, while an external source drives the system
   assign failEvent = control[CTRL_MONITOR_EN] && (state != ST_HALT)
                      && (currentSource == SRC_CRYSTAL || currentSource == SRC_USER_EXT)
                      && (silentCount == 8'(FAIL_CYCLES - 8'h1)) && !extEdge;

   // source switching and power mode sequencing
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state         <= ST_RUN;
         currentSource <= SRC_FAST_RC;
         stabCount     <= 8'h0;
         switchDone    <= 1'b0;
      end
      else
      begin
         switchDone <= 1'b0;
         if (failEvent)
         begin
            currentSource <= SRC_FAST_RC;
            state         <= ST_RUN;
         end
         else
         begin
            case (state)
               ST_RUN:
               begin
                  if (haltRequest)
                     state <= ST_HALT;
                  else if (selectReg != currentSource)
                     state <= ST_SWITCH;
               end
               ST_SWITCH:
               begin
                  if (haltRequest)
                     state <= ST_HALT;
                  else if (selectReg == currentSource)
                     state <= ST_RUN;
                  else if (sourceReady(selectReg))
                  begin
                     currentSource <= selectReg;
                     switchDone    <= 1'b1;
                     state         <= ST_RUN;
                  end
               end
               ST_HALT:
               begin
                  stabCount <= 8'h0;
                  if (wakeupEvent)
                  begin
                     currentSource <= SRC_FAST_RC;
                     state         <= ST_STABILIZE;
                  end
               end
               ST_STABILIZE:
               begin
                  stabCount <= 8'(stabCount + 8'h1);
                  // back to run; the saved selection is then restored by a switch
                  if (stabCount == 8'(STAB_CYCLES - 8'h1))
                     state <= ST_RUN;
               end
               default:
                  state <= ST_RUN;
            endcase
         end
      end
   end

   always_comb
   begin
      case (currentSource)
         SRC_FAST_RC: sourceTick = fastEdge;
         SRC_SLOW_RC: sourceTick = slowEdge;
         default:     sourceTick = extEdge;
      endcase
   end

   // stabilization always uses the fast RC at divide by eight
   assign effDiv     = (state == ST_STABILIZE) ? DIV_BY_EIGHT : divReg;
   assign restartDiv = switchDone | failEvent | (state == ST_HALT);
   assign running    = (state != ST_HALT);

   clock_tick_divider u_divider
   (
      .clock     (clock),
      .rst_n     (rst_n),
      .tickIn    (sourceTick),
      .divSelect (effDiv),
      .restart   (restartDiv),
      .tickOut   (divTick)
   );

   assign gateAll = {gate2, gate1};

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         sysTick  <= 1'b0;
         coreTick <= 1'b0;
      end
      else
      begin
         sysTick  <= divTick & running;
         coreTick <= divTick & running & ~control[CTRL_CORE_STOP];
      end
   end

   generate
      for (gi = 0; gi < 16; gi++)
      begin : g_gate
         always_ff @(posedge clock)
         begin
            if (!rst_n)
               periphTick[gi] <= 1'b0;
            else
               periphTick[gi] <= divTick & running & gateAll[gi];
         end
      end
   endgenerate

   // slow RC runs beside the system clock and keeps going in halt
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         watchdogTick <= 1'b0;
         awuTick      <= 1'b0;
      end
      else
      begin
         watchdogTick <= slowEdge;
         awuTick      <= slowEdge & gate2[GATE2_AWU];
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         trimValue <= TRIM_RESET;
      else
         trimValue <= trimCompat ? (trimReg & TRIM_COMPAT_MASK) : trimReg;
   end

   always_comb
   begin
      case (clockOutReg[2:1])
         2'h0:    outSelTick = divTick & running;
         2'h1:    outSelTick = fastEdge;
         2'h2:    outSelTick = slowEdge;
         default: outSelTick = extEdge;
      endcase
   end

   // the pin toggles per selected tick, giving half the tick rate as a square wave
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         clockOutPin    <= 1'b0;
         clockOutEnable <= 1'b0;
      end
      else
      begin
         clockOutEnable <= clockOutReg[CLKOUT_ENABLE];
         if (!clockOutReg[CLKOUT_ENABLE])
            clockOutPin <= 1'b0;
         else if (outSelTick)
            clockOutPin <= ~clockOutPin;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         halted       <= 1'b0;
         activeSource <= SRC_FAST_RC;
      end
      else
      begin
         halted       <= (state == ST_HALT);
         activeSource <= currentSource;
      end
   end

endmodule : system_clock_controller

// File: tb/clock_controller_props.sv
`timescale 1ns/1ps
module clock_controller_props
   import clock_controller_pkg::*;
(
   // clock and reset
   input wire logic        clock,
   input wire logic        rst_n,
   // register bus
   input wire logic        wbCyc,
   input wire logic        wbStb,
   input wire logic        wbAck,
   input wire logic [31:0] wbDatOut,
   // straps
   input wire logic        trimCompatSelect,
   input wire logic        slowRcSysclkAllow,
   // clocks and status
   input wire logic        sysTick,
   input wire logic        coreTick,
   input wire logic [15:0] periphTick,
   input wire logic        watchdogTick,
   input wire logic        awuTick,
   input wire logic [3:0]  trimValue,
   input wire logic        clockOutPin,
   input wire logic        clockOutEnable,
   input wire logic        irq,
   input wire logic        halted,
   input wire logic [1:0]  activeSource
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_ack_latency: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
      else $error("ack not one cycle after request");
   a_ack_pulse: assert property (wbAck |=> !wbAck)
      else $error("ack longer than one cycle");
   a_idle_data: assert property (!wbAck |-> wbDatOut == 32'h0)
      else $error("read data outside ack");
   a_halt_stops: assert property (halted && $past(halted) |-> !sysTick && !coreTick && periphTick == 16'h0)
      else $error("ticks during halt");
   a_reserved_quiet: assert property ((periphTick & 16'hF304) == 16'h0)
      else $error("reserved peripheral ticked");
   a_slow_allowed: assert property ($rose(activeSource == SRC_SLOW_RC) |-> slowRcSysclkAllow)
      else $error("slow source without option bit");
   a_awu_slow: assert property (awuTick |-> watchdogTick)
      else $error("wakeup tick without slow edge");
   a_clkout_off: assert property (!clockOutEnable && $past(!clockOutEnable) |-> !clockOutPin)
      else $error("clock output active while disabled");
   a_trim_compat: assert property (trimCompatSelect [*5] |=> !trimValue[2])
      else $error("trim bit two used in compat mode");

   cover property (irq);
   cover property ($rose(halted));
   cover property (activeSource == SRC_USER_EXT);
   cover property (awuTick);
endmodule : clock_controller_props

bind system_clock_controller clock_controller_props props (.clock(clock), .rst_n(rst_n), .wbCyc(wbCyc),
   .wbStb(wbStb), .wbAck(wbAck), .wbDatOut(wbDatOut), .trimCompatSelect(trimCompatSelect),
   .slowRcSysclkAllow(slowRcSysclkAllow), .sysTick(sysTick), .coreTick(coreTick), .periphTick(periphTick),
   .watchdogTick(watchdogTick), .awuTick(awuTick), .trimValue(trimValue), .clockOutPin(clockOutPin),
   .clockOutEnable(clockOutEnable), .irq(irq), .halted(halted), .activeSource(activeSource));

// File: tb/osc_model.sv
`timescale 1ns/1ps
module osc_model
(
   // controls from the bench
   input  wire logic extStop,
   input  wire logic crystalOn,
   // oscillator pins
   output logic      fastRcTick,
   output logic      slowRcTick,
   output logic      extClockTick,
   output logic      fastRcReady,
   output logic      slowRcReady,
   output logic      crystalReady
);
   // periods scaled below half the sampling rate, else the synchronisers would drop edges
   initial
   begin
      fastRcTick = 1'b0;
      slowRcTick = 1'b0;
      extClockTick = 1'b0;
   end
   always #175 fastRcTick = ~fastRcTick;
   always #650 slowRcTick = ~slowRcTick;
   // a failed external clock stands still
   always #235 extClockTick = extStop ? 1'b0 : ~extClockTick;
   assign fastRcReady = 1'b1;
   assign slowRcReady = 1'b1;
   assign crystalReady = crystalOn;
endmodule : osc_model

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import clock_controller_pkg::*;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        wbCyc = 1'b0;
   logic        wbStb = 1'b0;
   logic        wbWe = 1'b0;
   logic [7:0]  wbAdr = 8'h00;
   logic [3:0]  wbSel = 4'hF;
   logic [31:0] wbDatIn = 32'h0;
   logic        trimCompatSelect = 1'b0;
   logic        slowRcSysclkAllow = 1'b0;
   logic        haltRequest = 1'b0;
   logic        wakeupEvent = 1'b0;
   logic        extStop = 1'b0;
   logic        crystalOn = 1'b0;
   logic [31:0] wbDatOut, seed = 32'h58;
   logic        wbAck, fastRcTick, slowRcTick, extClockTick, fastRcReady, slowRcReady, crystalReady;
   logic        sysTick, coreTick, watchdogTick, awuTick, clockOutPin, clockOutEnable, irq, halted;
   logic [15:0] periphTick, pOr;
   logic [3:0]  trimValue, tv;
   logic [1:0]  activeSource;
   int          errors = 0, samples_checked = 0, cycles = 0, coreN, sysN, wdN, i;

   always #50 clock = ~clock;

   osc_model osc (.extStop(extStop), .crystalOn(crystalOn), .fastRcTick(fastRcTick), .slowRcTick(slowRcTick),
      .extClockTick(extClockTick), .fastRcReady(fastRcReady), .slowRcReady(slowRcReady),
      .crystalReady(crystalReady));
   system_clock_controller dut (.clock(clock), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
      .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
      .fastRcTick(fastRcTick), .slowRcTick(slowRcTick), .extClockTick(extClockTick),
      .fastRcReady(fastRcReady), .slowRcReady(slowRcReady), .crystalReady(crystalReady),
      .trimCompatSelect(trimCompatSelect), .slowRcSysclkAllow(slowRcSysclkAllow), .haltRequest(haltRequest),
      .wakeupEvent(wakeupEvent), .sysTick(sysTick), .coreTick(coreTick), .periphTick(periphTick),
      .watchdogTick(watchdogTick), .awuTick(awuTick), .trimValue(trimValue), .clockOutPin(clockOutPin),
      .clockOutEnable(clockOutEnable), .irq(irq), .halted(halted), .activeSource(activeSource));

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift

   function automatic logic [3:0] trim_expect(input logic [3:0] v, input logic compat);
      return compat ? (v & TRIM_COMPAT_MASK) : v;
   endfunction : trim_expect

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // the master waits for ack without assuming its latency
   task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [7:0] dat, output logic [31:0] rd);
      @(posedge clock);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatIn <= {24'h0, dat};
      do
      begin
         @(posedge clock);
      end
      while (wbAck !== 1'b1);
      rd = wbDatOut;
      check("ack", wbAck, 1'b1);
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
   endtask : wb_cycle

   task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
      logic [31:0] rd;
      wb_cycle(1'b1, adr, dat, rd);
   endtask : wr

   task automatic rdchk(input string name, input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      wb_cycle(1'b0, adr, 8'h00, rd);
      check(name, rd, exp);
   endtask : rdchk

   task automatic wait_src(input logic [1:0] s);
      int n;
      n = 0;
      while (activeSource !== s && n < 400)
      begin
         @(posedge clock);
         n++;
      end
      check("activeSource", activeSource, s);
   endtask : wait_src

   task automatic watch(input int n);
      pOr = 16'h0;
      coreN = 0;
      sysN = 0;
      wdN = 0;
      // skip ticks launched under old settings
      @(posedge clock);
      repeat (n)
      begin
         @(posedge clock);
         pOr = pOr | periphTick;
         coreN += int'(coreTick === 1'b1);
         sysN += int'(sysTick === 1'b1);
         wdN += int'(watchdogTick === 1'b1);
      end
   endtask : watch

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         end_of_test();
      end
   end

   initial
   begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      check("activeSource", activeSource, SRC_FAST_RC);
      rdchk("divider", ADDR_DIVIDER, DIV_BY_EIGHT);
      rdchk("gate1", ADDR_GATE_1, GATE_1_RESET);
      rdchk("gate2", ADDR_GATE_2, GATE_2_RESET);
      rdchk("unmapped", 8'hFC, 32'h0);
      for (i = 0; i < 4; i++)
      begin
         seed = xorshift(seed);
         wr(ADDR_GATE_1, seed[7:0]);
         rdchk("gate1", ADDR_GATE_1, seed[7:0] & GATE_1_VALID);
         wr(ADDR_GATE_2, seed[15:8]);
         rdchk("gate2", ADDR_GATE_2, seed[15:8] & GATE_2_VALID);
      end
      wr(ADDR_GATE_1, 8'h00);
      watch(60);
      check("gated ticks", pOr[7:0], 8'h00);
      wr(ADDR_GATE_1, 8'hFF);
      wr(ADDR_GATE_2, 8'hFF);
      watch(60);
      check("open ticks", pOr, {GATE_2_VALID, GATE_1_VALID});
      wr(ADDR_DIVIDER, 8'h00);
      watch(60);
      check("divide by one", sysN > 8, 1'b1);
      wr(ADDR_CONTROL, 8'h03);
      watch(60);
      check("core stopped", coreN, 0);
      check("system runs", sysN > 0, 1'b1);
      wr(ADDR_CONTROL, CONTROL_RESET);
      for (i = 0; i < 5; i++)
      begin
         seed = xorshift(seed);
         tv = (i == 0) ? 4'hF : seed[3:0];
         trimCompatSelect <= (i == 0) | seed[4];
         wr(ADDR_TRIM, {4'h0, tv});
         repeat (6) @(posedge clock);
         check("trim", trimValue, trim_expect(tv, trimCompatSelect));
      end
      trimCompatSelect <= 1'b0;
      wr(ADDR_SOURCE_SELECT, 8'h01);
      repeat (20) @(posedge clock);
      check("refused slow", activeSource, SRC_FAST_RC);
      slowRcSysclkAllow <= 1'b1;
      repeat (4) @(posedge clock);
      wr(ADDR_SOURCE_SELECT, 8'h01);
      wait_src(SRC_SLOW_RC);
      wr(ADDR_SOURCE_SELECT, 8'h02);
      repeat (30) @(posedge clock);
      check("old source kept", activeSource, SRC_SLOW_RC);
      crystalOn <= 1'b1;
      wait_src(SRC_CRYSTAL);
      wr(ADDR_SOURCE_SELECT, 8'h03);
      wait_src(SRC_USER_EXT);
      wr(ADDR_CLOCK_OUT, 8'h07);
      repeat (3) @(posedge clock);
      check("clock out enable", clockOutEnable, 1'b1);
      coreN = 0;
      repeat (40)
      begin
         tv[0] = clockOutPin;
         @(posedge clock);
         coreN += int'(clockOutPin !== tv[0]);
      end
      check("clock out toggles", coreN > 0, 1'b1);
      wr(ADDR_CLOCK_OUT, 8'h00);
      wr(ADDR_IRQ_MASK, 8'h01);
      extStop <= 1'b1;
      wait_src(SRC_FAST_RC);
      repeat (3) @(posedge clock);
      check("irq", irq, 1'b1);
      rdchk("divider", ADDR_DIVIDER, DIV_BY_EIGHT);
      wr(ADDR_IRQ_STATUS, 8'h03);
      repeat (3) @(posedge clock);
      check("irq cleared", irq, 1'b0);
      extStop <= 1'b0;
      wr(ADDR_SOURCE_SELECT, 8'h02);
      wait_src(SRC_CRYSTAL);
      haltRequest <= 1'b1;
      @(posedge clock);
      haltRequest <= 1'b0;
      repeat (3) @(posedge clock);
      check("halted", halted, 1'b1);
      watch(20);
      check("halt ticks", sysN, 0);
      check("watchdog in halt", wdN > 0, 1'b1);
      wakeupEvent <= 1'b1;
      @(posedge clock);
      wakeupEvent <= 1'b0;
      repeat (5) @(posedge clock);
      check("wake source", activeSource, SRC_FAST_RC);
      wait_src(SRC_CRYSTAL);
      end_of_test();
   end
endmodule : testbench
